// ---- rtl/isra_pkg.sv ----
/*
  Constants, register map and protocol states of the two-wire register
  port. Assumes nothing beyond a SystemVerilog compiler.
*/
package isra_pkg;

  // ==========================================================
  // Bus identity and framing
  localparam logic [6:0] ISRA_SLAVE_ADDR = 7'h28;
  localparam logic [3:0] ISRA_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ISRA_CNT_ZERO = 4'h0;
  localparam logic [3:0] ISRA_CNT_ONE = 4'h1;
  localparam logic [2:0] ISRA_MSB = 3'h7;
  localparam int ISRA_DIR_BIT = 0;

  // ==========================================================
  // Register map
  localparam int ISRA_NUM_REGS = 11;
  localparam logic [7:0] ISRA_REG_FIRST = 8'h00;
  localparam logic [7:0] ISRA_REG_LAST = 8'h0A;
  localparam logic [7:0] ISRA_REG_STEP = 8'h01;
  localparam logic [7:0] ISRA_DISCHARGE_CFG = 8'h05;
  localparam logic [7:0] ISRA_CHARGE_CFG = 8'h06;
  localparam logic [7:0] ISRA_FEATURE_CFG = 8'h07;
  localparam logic [7:0] ISRA_WRITE_UNLOCK = 8'h08;
  localparam logic [7:0] ISRA_REG_RESET = 8'h00;

  // Fields of the unlock register
  localparam int ISRA_FEATURE_UNLOCK_BIT = 7;
  localparam int ISRA_CHARGE_UNLOCK_BIT = 6;
  localparam int ISRA_DISCHARGE_UNLOCK_BIT = 5;

  // ==========================================================
  // Protocol states
  typedef enum logic [5:0] {
    ISRA_IDLE = 6'b000001,
    ISRA_ADDR = 6'b000010,
    ISRA_PTR = 6'b000100,
    ISRA_WDATA = 6'b001000,
    ISRA_RDATA = 6'b010000,
    ISRA_WAIT = 6'b100000
  } isra_state_e;

endpackage

// ---- rtl/isra_slave.sv ----
/*
  Two-wire slave port giving a bus master access to eleven 8-bit
  configuration registers, three of them write protected.
  Assumes SDA is open drain and resolved outside from sda_oe_n, and that
  the master's SCL is far slower than sys_clk (many cycles per phase).
*/
// What this block does
// R1: Master opens with start; nothing is answered until a start is seen.
// R2: SDA only changes while SCL is low, except start and stop.
// R3: Every byte moves most significant bit first.
// R4: Master ends each transaction with a stop after SDA is released.
// R5: A stop returns the port to standby.
// R6: Transmitter releases SDA after eight bits; receiver acks on ninth.
// R7: Slave byte is acked only on address match, else ignored.
// R8: Bus address is 0101000; slave byte bit 0 set means read.
// R9: In a write, pointer and every data byte are acknowledged.
// R10: Master writes slave byte, pointer, data bytes, then stop.
// R11: Data byte is stored at the SCL fall after its eighth bit.
// R12: Pointer steps after each written byte; wraps from 0AH to 0.
// R13: Master should not burst-write beyond register 08H.
// R14: Random read: pointer write, repeated start, read slave byte.
// R15: After read ack, one bit per clock, then release and sample ack.
// R16: Pointer steps after each read byte; ack continues reading.
// R17: A not-acknowledge stops transmission until the stop.
// R18: Master ends a read with not-acknowledge then stop.
// R19: Read without pointer uses the retained pointer.
// R20: Three configuration registers are locked after reset.
// R21: Unlock bits 7, 6, 5 of register 08H open registers 7, 6, 5.
// R22: Clearing an unlock bit locks its register again.
// R23: Locked register writes are acked but change nothing.
// R24: Start or stop in mid-byte aborts and resets the bit counter.
`timescale 1ns/1ps

module isra_slave
  import isra_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Two-wire bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Status
  output logic standby,
  // Configuration outputs
  output logic [7:0] discharge_threshold_config,
  output logic [7:0] charge_threshold_config,
  output logic [7:0] feature_config,
  output logic discharge_cfg_unlock,
  output logic charge_cfg_unlock,
  output logic feature_cfg_unlock
);
  import isra_pkg::*;

  // ==========================================================
  // Link domain: capture one bit per SCL rise
  // Initial values keep the toggle defined before SCL ever moves.
  logic rx_bit = 1'b0;
  logic rx_tgl = 1'b0;

  always_ff @(posedge scl) begin
    if (!rst_n) begin
      rx_bit <= 1'b0;
      rx_tgl <= 1'b0;
    end else begin
      rx_bit <= sda_in; // R3
      rx_tgl <= ~rx_tgl;
    end
  end

  // ==========================================================
  // Pin and toggle synchronisers (three stages, last two agree)
  logic scl_s1, scl_s2, scl_s3, scl_q, scl_d;
  logic sda_s1, sda_s2, sda_s3, sda_q, sda_d;
  logic tgl_s1, tgl_s2, tgl_s3, tgl_q, tgl_d;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tgl_q <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      tgl_d <= 1'b0;
    end else begin
      if (scl_s2 == scl_s3) begin
        scl_q <= scl_s3;
      end
      if (sda_s2 == sda_s3) begin
        sda_q <= sda_s3;
      end
      if (tgl_s2 == tgl_s3) begin
        tgl_q <= tgl_s3;
      end
      scl_d <= scl_q;
      sda_d <= sda_q;
      tgl_d <= tgl_q;
    end
  end

  // ==========================================================
  // Bus events
  isra_state_e state;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic rd_mode;
  logic master_nack;
  logic [7:0] regs [ISRA_NUM_REGS];

  logic start_ev, stop_ev, scl_fall, bit_ev, active;
  logic byte_end, ack_end, data_bit, addr_match, ptr_valid;
  logic [7:0] rd_data;
  logic [7:0] ptr_inc;
  logic wr_allowed;

  // Start and stop only count with SCL high on both samples.
  assign start_ev = scl_q & scl_d & sda_d & ~sda_q; // R1
  assign stop_ev = scl_q & scl_d & ~sda_d & sda_q; // R4
  assign scl_fall = scl_d & ~scl_q;
  // Rx bit is stable here: it only moves on the next SCL rise.
  assign bit_ev = tgl_q ^ tgl_d;
  assign active = (state == ISRA_ADDR) | (state == ISRA_PTR) |
                  (state == ISRA_WDATA) | (state == ISRA_RDATA);
  assign data_bit = bit_ev & active & ~ack_phase &
                    (bit_cnt < ISRA_BITS_PER_BYTE);
  assign byte_end = scl_fall & active & ~ack_phase &
                    (bit_cnt == ISRA_BITS_PER_BYTE); // R6
  assign ack_end = scl_fall & active & ack_phase;
  assign addr_match = (shreg[7:1] == ISRA_SLAVE_ADDR); // R8
  assign ptr_valid = (ptr <= ISRA_REG_LAST);
  assign rd_data = ptr_valid ? regs[ptr[3:0]] : ISRA_REG_RESET;
  assign ptr_inc = (ptr == ISRA_REG_LAST) ? ISRA_REG_FIRST :
                   ptr + ISRA_REG_STEP; // R12

  always_comb begin
    wr_allowed = ptr_valid;
    if (ptr == ISRA_DISCHARGE_CFG) begin
      wr_allowed = regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_DISCHARGE_UNLOCK_BIT];
    end else if (ptr == ISRA_CHARGE_CFG) begin
      wr_allowed = regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_CHARGE_UNLOCK_BIT];
    end else if (ptr == ISRA_FEATURE_CFG) begin
      wr_allowed = regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_FEATURE_UNLOCK_BIT];
    end
  end

  // ==========================================================
  // Protocol state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ISRA_IDLE;
    end else if (start_ev) begin
      state <= ISRA_ADDR; // R24
    end else if (stop_ev) begin
      state <= ISRA_IDLE; // R24
    end else if (byte_end) begin
      if (state == ISRA_ADDR && !addr_match) begin
        state <= ISRA_WAIT; // R7
      end
    end else if (ack_end) begin
      case (state)
        ISRA_ADDR: begin
          state <= rd_mode ? ISRA_RDATA : ISRA_PTR; // R10
        end
        ISRA_PTR: begin
          state <= ISRA_WDATA;
        end
        ISRA_RDATA: begin
          if (master_nack) begin
            state <= ISRA_WAIT; // R17
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ==========================================================
  // Bit counter and acknowledge slot
  always_ff @(posedge sys_clk) begin
    if (!rst_n || start_ev || stop_ev) begin
      bit_cnt <= ISRA_CNT_ZERO; // R24
      ack_phase <= 1'b0;
    end else if (data_bit) begin
      bit_cnt <= bit_cnt + ISRA_CNT_ONE;
    end else if (byte_end) begin
      ack_phase <= 1'b1;
    end else if (ack_end) begin
      ack_phase <= 1'b0;
      bit_cnt <= ISRA_CNT_ZERO;
    end
  end

  // ==========================================================
  // Receive shift register, direction and master acknowledge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shreg <= ISRA_REG_RESET;
    end else if (data_bit) begin
      shreg <= {shreg[6:0], rx_bit}; // R3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_mode <= 1'b0;
    end else if (byte_end && state == ISRA_ADDR) begin
      rd_mode <= shreg[ISRA_DIR_BIT]; // R8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || start_ev) begin
      master_nack <= 1'b0;
    end else if (bit_ev && ack_phase && state == ISRA_RDATA) begin
      master_nack <= rx_bit; // R15
    end
  end

  // ==========================================================
  // Register pointer; kept across transactions for plain reads
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr <= ISRA_REG_FIRST;
    end else if (byte_end && state == ISRA_PTR) begin
      ptr <= shreg; // R14
    end else if (byte_end && state == ISRA_RDATA) begin
      ptr <= ptr_inc; // R16
    end else if (ack_end && state == ISRA_WDATA) begin
      ptr <= ptr_inc; // R12
    end
  end

  // ==========================================================
  // Register file
  // Registers above the unlock one are plain storage; the master is
  // expected to keep out of them, nothing here stops it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ISRA_NUM_REGS; i++) begin
        regs[i] <= ISRA_REG_RESET; // R20
      end
    end else if (byte_end && state == ISRA_WDATA && wr_allowed) begin
      regs[ptr[3:0]] <= shreg; // R11 R21 R22 R23
    end
  end

  assign discharge_threshold_config = regs[ISRA_DISCHARGE_CFG[3:0]];
  assign charge_threshold_config = regs[ISRA_CHARGE_CFG[3:0]];
  assign feature_config = regs[ISRA_FEATURE_CFG[3:0]];
  assign discharge_cfg_unlock =
    regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_DISCHARGE_UNLOCK_BIT];
  assign charge_cfg_unlock =
    regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_CHARGE_UNLOCK_BIT];
  assign feature_cfg_unlock =
    regs[ISRA_WRITE_UNLOCK[3:0]][ISRA_FEATURE_UNLOCK_BIT];

  // ==========================================================
  // Transmit byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx <= ISRA_REG_RESET;
    end else if (ack_end && ((state == ISRA_ADDR && rd_mode) ||
                 (state == ISRA_RDATA && !master_nack))) begin
      tx <= rd_data; // R19
    end
  end

  // ==========================================================
  // SDA drive: changes only on SCL falls, so never while SCL is high
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || start_ev || stop_ev) begin
      sda_oe_n <= 1'b1;
    end else if (byte_end) begin
      if (state == ISRA_ADDR) begin
        sda_oe_n <= ~addr_match; // R7
      end else if (state == ISRA_RDATA) begin
        sda_oe_n <= 1'b1; // R15
      end else begin
        sda_oe_n <= 1'b0; // R9
      end
    end else if (ack_end) begin
      if ((state == ISRA_ADDR && rd_mode) ||
          (state == ISRA_RDATA && !master_nack)) begin
        sda_oe_n <= rd_data[ISRA_MSB]; // R15 R16
      end else begin
        sda_oe_n <= 1'b1; // R6 R17
      end
    end else if (scl_fall && state == ISRA_RDATA && !ack_phase &&
                 bit_cnt != ISRA_CNT_ZERO) begin
      sda_oe_n <= tx[ISRA_MSB - bit_cnt[2:0]]; // R2 R3
    end
  end

  // ==========================================================
  // Standby indication
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      standby <= 1'b1;
    end else if (start_ev) begin
      standby <= 1'b0;
    end else if (stop_ev) begin
      standby <= 1'b1; // R5
    end
  end

endmodule // isra_slave

// ---- sim/isra_slave_sva.sv ----
/*
  Port checker for the two-wire register slave, bound into isra_slave.
  Assumes SCL phases of many sys_clk cycles and SDA resolved outside.
*/
`timescale 1ns/1ps
module isra_slave_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic standby,
  // Configuration
  input wire logic [7:0] discharge_threshold_config,
  input wire logic [7:0] charge_threshold_config,
  input wire logic [7:0] feature_config,
  input wire logic discharge_cfg_unlock,
  input wire logic charge_cfg_unlock,
  input wire logic feature_cfg_unlock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  a_pull_only: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  a_reset_state: assert property ($rose(rst_n) |-> sda_oe_n && standby
    && feature_config == 8'h00 && charge_threshold_config == 8'h00
    && discharge_threshold_config == 8'h00 && !feature_cfg_unlock
    && !charge_cfg_unlock && !discharge_cfg_unlock)
    else $error("bad state after reset");
  a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("sda drive changed with scl high");
  a_drive_holds: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("sda drive too short");
  a_idle_release: assert property (standby |-> sda_oe_n)
    else $error("sda driven in standby");
  a_start_wakes: assert property (scl && $fell(sda_in)
    |-> ##[1:10] !standby) else $error("start not seen");
  a_stop_sleeps: assert property (scl && $rose(sda_in)
    |-> ##[1:10] standby) else $error("stop did not set standby");
  a_feature_lock: assert property ($changed(feature_config)
    |-> $past(feature_cfg_unlock)) else $error("locked feature write");
  a_charge_lock: assert property ($changed(charge_threshold_config)
    |-> $past(charge_cfg_unlock)) else $error("locked charge write");
  a_dis_lock: assert property ($changed(discharge_threshold_config)
    |-> $past(discharge_cfg_unlock)) else $error("locked discharge write");
endmodule // isra_slave_sva

bind isra_slave isra_slave_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .standby(standby), .feature_config(feature_config),
  .discharge_threshold_config(discharge_threshold_config),
  .charge_threshold_config(charge_threshold_config),
  .discharge_cfg_unlock(discharge_cfg_unlock),
  .charge_cfg_unlock(charge_cfg_unlock),
  .feature_cfg_unlock(feature_cfg_unlock));

// ---- sim/isra_host_model.sv ----
/*
  Bus master model: makes SCL (160 ns, idle high) and drives SDA open
  drain. Assumes the bench resolves the wire and calls its tasks.
*/
`timescale 1ns/1ps
module isra_host_model (
  // Bus
  output logic scl,
  output logic sda_drv,
  input wire logic sda,
  // Results
  output logic [7:0] res,
  output logic res_valid
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    res = 8'h00;
    res_valid = 1'b0;
  end
  task automatic bit_io(input logic b, output logic q);
    sda_drv = b;
    #60 scl = 1'b1;
    #80 q = sda;
    scl = 1'b0;
    #20;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    #60 scl = 1'b1;
    #80 sda_drv = 1'b0;
    #80 scl = 1'b0;
    #20;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #60 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask
  task automatic post(input logic [7:0] v);
    res = v;
    res_valid = 1'b1;
    #1 res_valid = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    logic q;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q);
    bit_io(1'b1, a);
    post({7'h00, ~a});
  endtask
  task automatic rd(input logic last);
    logic [7:0] d;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, a);
    post(d);
  endtask
endmodule // isra_host_model

// ---- sim/isra_slave_tb_top.sv ----
/*
  Self-checking bench for isra_slave with the bus master model.
  Assumes a pull-up on SDA, modelled by the wired-and below.
*/
`timescale 1ns/1ps
module isra_slave_tb_top;
  import isra_pkg::*;
  logic sys_clk, rst_n, scl, sda_drv, sda_w, sda_out, sda_oe_n, standby;
  logic res_valid, q, dis_un, chg_un, fea_un;
  logic [7:0] dis_cfg, chg_cfg, fea_cfg, res;
  logic [7:0] rnd [3];
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'h35444856;
  assign sda_w = (sda_oe_n | sda_out) & sda_drv;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  isra_slave DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .standby(standby), .discharge_threshold_config(dis_cfg),
    .charge_threshold_config(chg_cfg), .feature_config(fea_cfg),
    .discharge_cfg_unlock(dis_un), .charge_cfg_unlock(chg_un),
    .feature_cfg_unlock(fea_un));
  isra_host_model u_host (.scl(scl), .sda_drv(sda_drv), .sda(sda_w),
    .res(res), .res_valid(res_valid));
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s exp=%h seen=%h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge res_valid) begin
    check("bus result", res, exp_q.pop_front());
  end
  // ==========================================================
  // Bus helpers
  task automatic wr(input logic [7:0] d, input logic ack);
    exp_q.push_back({7'h00, ack});
    u_host.wr(d);
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    u_host.rd(last);
  endtask
  task automatic wbegin(input logic [7:0] p);
    u_host.start();
    wr({ISRA_SLAVE_ADDR, 1'b0}, 1'b1);
    wr(p, 1'b1);
  endtask
  task automatic rbegin(input logic [7:0] p);
    wbegin(p);
    u_host.start();
    wr({ISRA_SLAVE_ADDR, 1'b1}, 1'b1);
  endtask
  // ==========================================================
  // Sequence
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    check("standby", {7'h00, standby}, 8'h01);
    foreach (rnd[i]) rnd[i] = 8'($random(seed));
    wbegin(ISRA_DISCHARGE_CFG);
    foreach (rnd[i]) wr(rnd[i], 1'b1);
    wr(8'hE0, 1'b1);
    u_host.stop();
    check("locked", dis_cfg | chg_cfg | fea_cfg, 8'h00);
    check("unlock", {5'h00, fea_un, chg_un, dis_un}, 8'h07);
    wbegin(ISRA_DISCHARGE_CFG);
    foreach (rnd[i]) wr(rnd[i], 1'b1);
    u_host.stop();
    check("dis", dis_cfg, rnd[0]);
    check("chg", chg_cfg, rnd[1]);
    check("fea", fea_cfg, rnd[2]);
    rbegin(ISRA_DISCHARGE_CFG);
    rd(rnd[0], 1'b0);
    rd(rnd[1], 1'b1);
    u_host.stop();
    u_host.start();
    wr({ISRA_SLAVE_ADDR, 1'b1}, 1'b1);
    rd(rnd[2], 1'b1);
    u_host.stop();
    check("standby", {7'h00, standby}, 8'h01);
    // Bursts stay clear of the reserved top locations; wrap seen on reads
    wbegin(ISRA_REG_FIRST);
    wr(8'h5A, 1'b1);
    wr(8'hA5, 1'b1);
    u_host.stop();
    rbegin(ISRA_REG_LAST);
    rd(ISRA_REG_RESET, 1'b0);
    rd(8'h5A, 1'b0);
    rd(8'hA5, 1'b1);
    u_host.stop();
    wbegin(ISRA_WRITE_UNLOCK);
    wr(8'h00, 1'b1);
    u_host.stop();
    wbegin(ISRA_FEATURE_CFG);
    wr(~rnd[2], 1'b1);
    u_host.stop();
    check("relocked", fea_cfg, rnd[2]);
    u_host.start();
    wr({ISRA_SLAVE_ADDR ^ (rnd[0][6:0] | 7'h01), 1'b0}, 1'b0);
    wr(ISRA_WRITE_UNLOCK, 1'b0);
    u_host.stop();
    u_host.start();
    repeat (4) u_host.bit_io(1'b1, q);
    wbegin(ISRA_WRITE_UNLOCK);
    wr(8'h20, 1'b1);
    u_host.stop();
    check("abort", {5'h00, fea_un, chg_un, dis_un}, 8'h01);
    finish_test();
  end
  initial begin
    #300000;
    error_cnt++;
    finish_test();
  end
endmodule // isra_slave_tb_top
